// File: shared/acps_pkg.sv
// Constants, register map and state types of the calibration and power-down sequencer
package acps_pkg;

  // ***************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ***************************************************************
  localparam logic [7:0] ACPS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] ACPS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] ACPS_ADDR_DATA = 8'h08;
  localparam logic [7:0] ACPS_ADDR_DECIM = 8'h0C;
  localparam logic [7:0] ACPS_ADDR_OFFSET0 = 8'h10;
  localparam logic [7:0] ACPS_ADDR_GAIN0 = 8'h14;
  localparam logic [7:0] ACPS_ADDR_OFFSET1 = 8'h18;
  localparam logic [7:0] ACPS_ADDR_GAIN1 = 8'h1C;

  // ***************************************************************
  // Control register fields
  // ***************************************************************
  localparam int unsigned ACPS_CTRL_MODE_LO = 0;
  localparam int unsigned ACPS_CTRL_MODE_HI = 1;
  localparam int unsigned ACPS_CTRL_PD = 2;
  localparam int unsigned ACPS_CTRL_FILTER_SYNC_HOLD = 3;
  localparam int unsigned ACPS_CTRL_CHAN = 4;
  localparam int unsigned ACPS_CTRL_BIPOLAR = 5;
  localparam int unsigned ACPS_CTRL_CLOCK_OUT_DISABLE = 6;
  localparam int unsigned ACPS_CTRL_OSC_INT = 7;
  localparam logic ACPS_FILTER_SYNC_HOLD_RESET = 1'b1;

  // ***************************************************************
  // Calibration mode codes
  // ***************************************************************
  localparam logic [1:0] ACPS_CAL_NONE = 2'h0;
  localparam logic [1:0] ACPS_CAL_SELF = 2'h1;
  localparam logic [1:0] ACPS_CAL_ZERO = 2'h2;
  localparam logic [1:0] ACPS_CAL_FULL = 2'h3;

  // ***************************************************************
  // Timing, in output-data-rate periods and master clock periods
  // ***************************************************************
  localparam logic [3:0] ACPS_SELF_CAL_ODR = 4'h6;
  localparam logic [3:0] ACPS_SELF_ZERO_ODR = 4'h3;
  localparam logic [3:0] ACPS_SYS_CAL_ODR = 4'h3;
  localparam logic [3:0] ACPS_FIRST_CONV_ODR = 4'h3;
  localparam logic [3:0] ACPS_SYS_CONV_ODR = 4'h1;
  localparam logic [3:0] ACPS_FREE_CONV_ODR = 4'h1;
  localparam logic [6:0] ACPS_MOD_CYCLE_LAST = 7'h7F;
  localparam int unsigned ACPS_MOD_CYCLE_MCLK = 128;
  localparam int unsigned ACPS_PIPELINE_DELAY_MCLK = 2000;
  localparam logic [15:0] ACPS_DECIM_RESET = 16'h0187;
  localparam logic [15:0] ACPS_MIDSCALE = 16'h8000;
  localparam logic [15:0] ACPS_COEF_RESET = 16'h0000;

  // ***************************************************************
  // Sequencer state
  // ***************************************************************
  typedef enum logic [2:0] {
    ACPS_ST_HOLD,
    ACPS_ST_DOWN,
    ACPS_ST_PIPE,
    ACPS_ST_CAL,
    ACPS_ST_CONV
  } acps_state_t;

  typedef struct packed {
    acps_state_t st;
    logic [1:0] cal_mode;
    logic [1:0] cal_run;
    logic power_down;
    logic filter_sync_hold;
    logic chan;
    logic bipolar;
    logic clock_out_disable;
    logic osc_int;
    logic [15:0] decim;
    logic [1:0][15:0] offset;
    logic [1:0][15:0] gain;
    logic [15:0] data;
    logic ready_n;
    logic raise_pend;
    logic [3:0] odr_cnt;
    logic [3:0] odr_tgt;
    logic [23:0] mclk_cnt;
    logic [6:0] mod_cnt;
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_s3;
    logic clk_out;
    logic osc_en;
    logic mod_rst;
    logic short_in;
    logic ref_in;
    logic ack;
    logic [31:0] dat;
  } acps_regs_t;

endpackage

// File: hw/acps_sequencer.sv
// Calibration and power-down sequencer with a classic Wishbone register slave
`timescale 1ns/1ns

module acps_sequencer
  import acps_pkg::*;
#(
  parameter int unsigned PIPELINE_DELAY_MCLK = ACPS_PIPELINE_DELAY_MCLK
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converter link
  input wire logic master_clock_input_i,
  input wire logic [15:0] conv_data_i,
  // Converter controls
  output logic result_ready_n_o,
  output logic modulator_reset_o,
  output logic input_short_o,
  output logic input_ref_o,
  output logic osc_enable_o,
  output logic clock_output_pin_o
);

  // ***************************************************************
  // Local constants
  // ***************************************************************
  localparam logic [23:0] TP_LAST = 24'(PIPELINE_DELAY_MCLK - 1);
  // Status word fields
  localparam int unsigned STAT_READY = 0;
  localparam int unsigned STAT_STATE_LO = 1;
  localparam int unsigned STAT_STATE_HI = 3;
  localparam int unsigned STAT_PEND = 4;
  // Coefficient address bits: gain versus offset, then channel
  localparam int unsigned COEF_GAIN_BIT = 2;
  localparam int unsigned COEF_CHAN_BIT = 3;

  // ***************************************************************
  // Sequencer state
  // ***************************************************************
  acps_regs_t r_reg;
  acps_regs_t r_next;

  // ***************************************************************
  // Combinational next state
  // ***************************************************************
  logic mclk_rise;
  logic odr_last;
  logic [23:0] odr_len;
  logic start_cal;
  logic [1:0] new_mode;
  logic [15:0] zero_code;
  logic [15:0] cur_offset;
  logic coef_gain;
  logic coef_chan;

  always_comb begin
    r_next = r_reg;
    start_cal = 1'b0;
    new_mode = ACPS_CAL_NONE;
    coef_gain = wb_adr_i[COEF_GAIN_BIT];
    coef_chan = wb_adr_i[COEF_CHAN_BIT];
    // Master clock passes two flops before its edge is looked for
    r_next.mclk_s1 = master_clock_input_i;
    r_next.mclk_s2 = r_reg.mclk_s1;
    r_next.mclk_s3 = r_reg.mclk_s2;
    mclk_rise = r_reg.mclk_s2 & ~r_reg.mclk_s3;
    odr_len = 24'(r_reg.decim) * 24'(ACPS_MOD_CYCLE_MCLK);
    odr_last = (r_reg.mclk_cnt == odr_len - 24'h000001);
    zero_code = r_reg.bipolar ? ACPS_MIDSCALE : ACPS_COEF_RESET;
    cur_offset = r_reg.offset[r_reg.chan];

    // *************************************************************
    // Bus slave: one wait state, ack dropped the cycle after
    // *************************************************************
    r_next.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      r_next.ack = 1'b1;
      r_next.dat = 32'h00000000;
      if (wb_we_i) begin
        case (wb_adr_i)
          ACPS_ADDR_CTRL: begin
            if (wb_sel_i[0]) begin
              new_mode = {wb_dat_i[ACPS_CTRL_MODE_HI], wb_dat_i[ACPS_CTRL_MODE_LO]};
              r_next.cal_mode = new_mode;
              r_next.power_down = wb_dat_i[ACPS_CTRL_PD];
              r_next.filter_sync_hold = wb_dat_i[ACPS_CTRL_FILTER_SYNC_HOLD];
              r_next.chan = wb_dat_i[ACPS_CTRL_CHAN];
              r_next.bipolar = wb_dat_i[ACPS_CTRL_BIPOLAR];
              r_next.clock_out_disable = wb_dat_i[ACPS_CTRL_CLOCK_OUT_DISABLE];
              r_next.osc_int = wb_dat_i[ACPS_CTRL_OSC_INT];
              start_cal = (new_mode != ACPS_CAL_NONE);
            end
          end
          ACPS_ADDR_DECIM: begin
            if (wb_sel_i[0]) begin
              r_next.decim[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
              r_next.decim[15:8] = wb_dat_i[15:8];
            end
          end
          ACPS_ADDR_OFFSET0, ACPS_ADDR_GAIN0, ACPS_ADDR_OFFSET1, ACPS_ADDR_GAIN1: begin
            if (coef_gain) begin
              if (wb_sel_i[0]) begin
                r_next.gain[coef_chan][7:0] = wb_dat_i[7:0];
              end
              if (wb_sel_i[1]) begin
                r_next.gain[coef_chan][15:8] = wb_dat_i[15:8];
              end
            end else begin
              if (wb_sel_i[0]) begin
                r_next.offset[coef_chan][7:0] = wb_dat_i[7:0];
              end
              if (wb_sel_i[1]) begin
                r_next.offset[coef_chan][15:8] = wb_dat_i[15:8];
              end
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (wb_adr_i)
          ACPS_ADDR_CTRL: begin
            r_next.dat[ACPS_CTRL_MODE_LO] = r_reg.cal_mode[0];
            r_next.dat[ACPS_CTRL_MODE_HI] = r_reg.cal_mode[1];
            r_next.dat[ACPS_CTRL_PD] = r_reg.power_down;
            r_next.dat[ACPS_CTRL_FILTER_SYNC_HOLD] = r_reg.filter_sync_hold;
            r_next.dat[ACPS_CTRL_CHAN] = r_reg.chan;
            r_next.dat[ACPS_CTRL_BIPOLAR] = r_reg.bipolar;
            r_next.dat[ACPS_CTRL_CLOCK_OUT_DISABLE] = r_reg.clock_out_disable;
            r_next.dat[ACPS_CTRL_OSC_INT] = r_reg.osc_int;
          end
          ACPS_ADDR_STATUS: begin
            r_next.dat[STAT_READY] = r_reg.ready_n;
            r_next.dat[STAT_STATE_HI:STAT_STATE_LO] = r_reg.st;
            r_next.dat[STAT_PEND] = r_reg.raise_pend;
          end
          ACPS_ADDR_DATA: begin
            r_next.dat[15:0] = r_reg.data;
            r_next.ready_n = 1'b1;
          end
          ACPS_ADDR_DECIM: begin
            r_next.dat[15:0] = r_reg.decim;
          end
          ACPS_ADDR_OFFSET0, ACPS_ADDR_GAIN0, ACPS_ADDR_OFFSET1, ACPS_ADDR_GAIN1: begin
            r_next.dat[15:0] = coef_gain ? r_reg.gain[coef_chan] : r_reg.offset[coef_chan];
          end
          default: begin
          end
        endcase
      end
    end

    // *************************************************************
    // Modulator cycle phase, used to delay the ready rise
    // *************************************************************
    if (mclk_rise) begin
      r_next.mod_cnt = r_reg.mod_cnt + 7'h01;
      if (r_reg.raise_pend && r_reg.mod_cnt == ACPS_MOD_CYCLE_LAST) begin
        r_next.ready_n = 1'b1;
        r_next.raise_pend = 1'b0;
      end
    end

    // *************************************************************
    // Calibration command: restart the whole sequence
    // *************************************************************
    if (start_cal) begin
      r_next.cal_run = new_mode;
      r_next.mclk_cnt = 24'h000000;
      r_next.odr_cnt = 4'h0;
      if (r_next.st != ACPS_ST_HOLD && r_next.st != ACPS_ST_DOWN) begin
        r_next.st = ACPS_ST_PIPE;
      end
      if (!r_reg.ready_n) begin
        r_next.raise_pend = 1'b1;
      end
    end

    // *************************************************************
    // Sequencer
    // *************************************************************
    case (r_reg.st)
      ACPS_ST_HOLD, ACPS_ST_DOWN: begin
        // Registers keep their values; ready left as it stands
        if (!r_next.filter_sync_hold && !r_next.power_down) begin
          r_next.st = ACPS_ST_PIPE;
          r_next.mclk_cnt = 24'h000000;
          r_next.odr_cnt = 4'h0;
          r_next.cal_run = r_next.cal_mode;
          if (r_next.cal_mode != ACPS_CAL_NONE && !r_next.ready_n) begin
            r_next.raise_pend = 1'b1;
          end
        end
      end
      ACPS_ST_PIPE: begin
        // Pipeline delay before the first valid modulator result
        if (mclk_rise && !start_cal) begin
          r_next.mclk_cnt = r_reg.mclk_cnt + 24'h000001;
          if (r_reg.mclk_cnt == TP_LAST) begin
            r_next.mclk_cnt = 24'h000000;
            r_next.odr_cnt = 4'h0;
            if (r_reg.cal_run != ACPS_CAL_NONE) begin
              r_next.st = ACPS_ST_CAL;
              r_next.odr_tgt = (r_reg.cal_run == ACPS_CAL_SELF) ?
                ACPS_SELF_CAL_ODR : ACPS_SYS_CAL_ODR;
            end else begin
              r_next.st = ACPS_ST_CONV;
              r_next.odr_tgt = ACPS_FIRST_CONV_ODR;
            end
          end
        end
      end
      ACPS_ST_CAL: begin
        // Calibration steps counted in output periods
        if (mclk_rise && !start_cal) begin
          r_next.mclk_cnt = r_reg.mclk_cnt + 24'h000001;
          if (odr_last) begin
            r_next.mclk_cnt = 24'h000000;
            r_next.odr_cnt = r_reg.odr_cnt + 4'h1;
            // Zero-scale step ends: offset of the selected channel
            if ((r_reg.cal_run == ACPS_CAL_SELF &&
                 r_next.odr_cnt == ACPS_SELF_ZERO_ODR) ||
                (r_reg.cal_run == ACPS_CAL_ZERO &&
                 r_next.odr_cnt == ACPS_SYS_CAL_ODR)) begin
              r_next.offset[r_reg.chan] = conv_data_i - zero_code;
            end
            if (r_next.odr_cnt == r_reg.odr_tgt) begin
              // Last step ends: gain of the selected channel after a self or full-scale calibration
              if (r_reg.cal_run == ACPS_CAL_SELF || r_reg.cal_run == ACPS_CAL_FULL) begin
                r_next.gain[r_reg.chan] = conv_data_i - cur_offset;
              end
              r_next.cal_mode = ACPS_CAL_NONE;
              r_next.st = ACPS_ST_CONV;
              r_next.odr_cnt = 4'h0;
              r_next.odr_tgt = (r_reg.cal_run == ACPS_CAL_SELF) ?
                ACPS_FIRST_CONV_ODR : ACPS_SYS_CONV_ODR;
              r_next.cal_run = ACPS_CAL_NONE;
            end
          end
        end
      end
      ACPS_ST_CONV: begin
        // Free-running conversions at the output rate
        if (mclk_rise && !start_cal) begin
          r_next.mclk_cnt = r_reg.mclk_cnt + 24'h000001;
          if (odr_last) begin
            r_next.mclk_cnt = 24'h000000;
            r_next.odr_cnt = r_reg.odr_cnt + 4'h1;
            if (r_next.odr_cnt == r_reg.odr_tgt) begin
              // Fresh result beats a read clearing ready in the same cycle
              r_next.data = conv_data_i - cur_offset + zero_code;
              r_next.ready_n = 1'b0;
              r_next.raise_pend = 1'b0;
              r_next.odr_cnt = 4'h0;
              r_next.odr_tgt = ACPS_FREE_CONV_ODR;
            end
          end
        end
      end
      default: begin
        r_next.st = ACPS_ST_HOLD;
      end
    endcase

    // *************************************************************
    // Sync hold and power-down stop the sequence at once
    // *************************************************************
    if (r_next.filter_sync_hold) begin
      r_next.st = ACPS_ST_HOLD;
      r_next.mclk_cnt = 24'h000000;
      r_next.odr_cnt = 4'h0;
    end else if (r_next.power_down) begin
      r_next.st = ACPS_ST_DOWN;
      r_next.mclk_cnt = 24'h000000;
      r_next.odr_cnt = 4'h0;
    end

    // *************************************************************
    // Pin controls
    // *************************************************************
    r_next.mod_rst = (r_next.st == ACPS_ST_HOLD) || (r_next.st == ACPS_ST_DOWN);
    r_next.short_in = (r_next.st == ACPS_ST_CAL) && (r_next.cal_run == ACPS_CAL_SELF) &&
                      (r_next.odr_cnt < ACPS_SELF_ZERO_ODR);
    r_next.ref_in = (r_next.st == ACPS_ST_CAL) && (r_next.cal_run == ACPS_CAL_SELF) &&
                    (r_next.odr_cnt >= ACPS_SELF_ZERO_ODR);
    r_next.osc_en = !(r_next.osc_int && r_next.power_down);
    r_next.clk_out = !r_next.clock_out_disable && r_reg.mclk_s2 &&
                     !(r_next.osc_int && r_next.power_down);
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      r_reg.st <= ACPS_ST_HOLD;
      r_reg.cal_mode <= ACPS_CAL_NONE;
      r_reg.cal_run <= ACPS_CAL_NONE;
      r_reg.power_down <= 1'b0;
      r_reg.filter_sync_hold <= ACPS_FILTER_SYNC_HOLD_RESET;
      r_reg.chan <= 1'b0;
      r_reg.bipolar <= 1'b0;
      r_reg.clock_out_disable <= 1'b0;
      r_reg.osc_int <= 1'b0;
      r_reg.decim <= ACPS_DECIM_RESET;
      r_reg.offset <= {ACPS_COEF_RESET, ACPS_COEF_RESET};
      r_reg.gain <= {ACPS_COEF_RESET, ACPS_COEF_RESET};
      r_reg.data <= ACPS_COEF_RESET;
      r_reg.ready_n <= 1'b1;
      r_reg.raise_pend <= 1'b0;
      r_reg.odr_cnt <= 4'h0;
      r_reg.odr_tgt <= 4'h0;
      r_reg.mclk_cnt <= 24'h000000;
      r_reg.mod_cnt <= 7'h00;
      r_reg.mclk_s1 <= 1'b0;
      r_reg.mclk_s2 <= 1'b0;
      r_reg.mclk_s3 <= 1'b0;
      r_reg.clk_out <= 1'b0;
      r_reg.osc_en <= 1'b1;
      r_reg.mod_rst <= 1'b1;
      r_reg.short_in <= 1'b0;
      r_reg.ref_in <= 1'b0;
      r_reg.ack <= 1'b0;
      r_reg.dat <= 32'h00000000;
    end else begin
      r_reg <= r_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign result_ready_n_o = r_reg.ready_n;
  assign modulator_reset_o = r_reg.mod_rst;
  assign input_short_o = r_reg.short_in;
  assign input_ref_o = r_reg.ref_in;
  assign osc_enable_o = r_reg.osc_en;
  assign clock_output_pin_o = r_reg.clk_out;

endmodule // acps_sequencer

// File: verification/acps_sequencer_assertions.sv
// Port checker for the calibration and power-down sequencer
`timescale 1ns/1ns
module acps_sequencer_checker
  import acps_pkg::*;
(
  // Clock, reset and bus
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Converter side
  input wire logic master_clock_input_i,
  input wire logic [15:0] conv_data_i,
  input wire logic result_ready_n_o,
  input wire logic modulator_reset_o,
  input wire logic input_short_o,
  input wire logic input_ref_o,
  input wire logic osc_enable_o,
  input wire logic clock_output_pin_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic req;
  logic rd_data;
  logic pd_wr;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_data = req && !wb_we_i && wb_adr_i == ACPS_ADDR_DATA;
  assign pd_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == ACPS_ADDR_CTRL
    && wb_dat_i[ACPS_CTRL_PD] && wb_dat_i[1:0] == ACPS_CAL_NONE;
  // ***************************************************************
  // Properties
  // ***************************************************************
  a_ack_answers: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_read_clears: assert property (rd_data |=> result_ready_n_o)
    else $error("ready still low after data read");
  a_pd_keeps_ready: assert property (pd_wr |=> $stable(result_ready_n_o) [*2])
    else $error("power-down write moved ready");
  a_steps_exclusive: assert property (!(input_short_o && input_ref_o))
    else $error("short and reference steps overlap");
  a_ref_after_short: assert property ($rose(input_ref_o) |-> $past(input_short_o))
    else $error("reference step without zero step before it");
  a_hold_no_steps: assert property (modulator_reset_o |-> !input_short_o && !input_ref_o)
    else $error("calibration step while held");
  a_fall_needs_run: assert property ($fell(result_ready_n_o) |-> !$past(modulator_reset_o)
    && !input_short_o && !input_ref_o)
    else $error("ready fell without a fresh conversion");
  a_osc_off_clk: assert property (!osc_enable_o [*2] |-> !clock_output_pin_o)
    else $error("clock output runs with oscillator off");
  a_reset_state: assert property ($rose(rst_n_i) |-> result_ready_n_o && modulator_reset_o
    && osc_enable_o && !wb_ack_o)
    else $error("outputs not at reset values");
endmodule // acps_sequencer_checker

bind acps_sequencer acps_sequencer_checker u_checker (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .master_clock_input_i(master_clock_input_i), .conv_data_i(conv_data_i),
  .result_ready_n_o(result_ready_n_o), .modulator_reset_o(modulator_reset_o),
  .input_short_o(input_short_o), .input_ref_o(input_ref_o), .osc_enable_o(osc_enable_o),
  .clock_output_pin_o(clock_output_pin_o));

// File: verification/acps_conv_model.sv
// Behavioural converter front end: master clock and modulator codes
`timescale 1ns/1ns
module acps_conv_model #(
  parameter logic [15:0] ZERO_CODE = 16'h0000,
  parameter logic [15:0] FULL_CODE = 16'hFFFF
) (
  // Controls from the sequencer, input level from the testbench
  input wire logic osc_enable_i,
  input wire logic input_short_i,
  input wire logic input_ref_i,
  input wire logic [15:0] level_i,
  // Clock and codes to the sequencer
  output logic master_clock_o,
  output logic [15:0] conv_data_o
);
  initial begin
    master_clock_o = 1'b0;
    forever begin
      #400;
      if (osc_enable_i) begin
        master_clock_o = ~master_clock_o;
      end
    end
  end
  always_comb begin
    if (input_short_i) begin
      conv_data_o = ZERO_CODE;
    end else if (input_ref_i) begin
      conv_data_o = FULL_CODE;
    end else begin
      conv_data_o = level_i;
    end
  end
endmodule // acps_conv_model

// File: verification/tb.sv
// Testbench for the calibration and power-down sequencer
`timescale 1ns/1ns
module tb
  import acps_pkg::*;
;
  localparam logic [15:0] ZC = 16'h1234;
  localparam logic [15:0] FC = 16'hE000;
  localparam int TP = 4;
  logic clock_i, rst_n_i, cyc, stb, we, ack, mclk, rdy_n, mod_rst, shrt, refv, osc_en, clk_pin, c;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [15:0] conv, level;
  int err_count, n_checks, cycles, t0;
  acps_sequencer #(.PIPELINE_DELAY_MCLK(TP)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .master_clock_input_i(mclk),
    .conv_data_i(conv), .result_ready_n_o(rdy_n), .modulator_reset_o(mod_rst),
    .input_short_o(shrt), .input_ref_o(refv), .osc_enable_o(osc_en), .clock_output_pin_o(clk_pin));
  acps_conv_model #(.ZERO_CODE(ZC), .FULL_CODE(FC)) u_model (.osc_enable_i(osc_en),
    .input_short_i(shrt), .input_ref_i(refv), .level_i(level), .master_clock_o(mclk),
    .conv_data_o(conv));
  initial begin
    clock_i = 1'b0;
    forever begin
      #50 clock_i = ~clock_i;
    end
  end
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
  end
  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  function automatic int odr_clk(input int n);
    return (TP + n * 128) * 8;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic span(input int lo, input int hi);
    chk(32'(cycles - t0 >= lo && cycles - t0 <= hi), 32'h1);
    if (cycles - t0 > hi) begin
      end_of_test();
    end
  endtask
  task automatic wait_rdy(input logic v, input int lo, input int hi);
    while (rdy_n !== v && cycles - t0 <= hi) begin
      @(negedge clock_i);
    end
    span(lo, hi);
  endtask
  task automatic wait_odr(input int n);
    wait_rdy(1'b0, odr_clk(n) - 16, odr_clk(n) + 40);
  endtask
  task automatic wait_mode(input int n);
    do begin
      bus(1'b0, ACPS_ADDR_CTRL, 32'h0);
    end while (q[1:0] !== ACPS_CAL_NONE && cycles - t0 <= odr_clk(n) + 40);
    span(odr_clk(n) - 16, odr_clk(n) + 40);
  endtask
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_reset();
    @(negedge clock_i);
    chk(32'(rdy_n), 32'h1);
    chk(32'(mod_rst), 32'h1);
    rd(ACPS_ADDR_CTRL, 32'h8);
    bus(1'b1, 8'hF0, 32'h1234);
    rd(8'hF0, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_self();
    bus(1'b1, ACPS_ADDR_DECIM, 32'h1);
    bus(1'b1, ACPS_ADDR_CTRL, 32'h1);
    repeat (1500) @(negedge clock_i);
    chk(32'(shrt), 32'h1);
    bus(1'b1, ACPS_ADDR_CTRL, 32'h1);
    t0 = cycles;
    repeat (4000) @(negedge clock_i);
    chk(32'(refv), 32'h1);
    chk(32'(shrt), 32'h0);
    wait_mode(6);
    wait_odr(9);
    rd(ACPS_ADDR_OFFSET0, 32'(ZC));
    rd(ACPS_ADDR_GAIN0, 32'(FC - ZC));
    rd(ACPS_ADDR_OFFSET1, 32'h0);
    $display("test self calibration done");
  endtask
  task automatic t_sys();
    level <= 16'h8100;
    bus(1'b1, ACPS_ADDR_CTRL, 32'h32);
    t0 = cycles;
    wait_rdy(1'b1, 0, 1100);
    wait_mode(3);
    wait_odr(4);
    rd(ACPS_ADDR_OFFSET1, 32'h100);
    level <= 16'hF000;
    bus(1'b1, ACPS_ADDR_CTRL, 32'h33);
    t0 = cycles;
    wait_rdy(1'b1, 0, 1100);
    wait_mode(3);
    wait_odr(4);
    rd(ACPS_ADDR_GAIN1, 32'hEF00);
    rd(ACPS_ADDR_OFFSET0, 32'(ZC));
    rd(ACPS_ADDR_DATA, 32'h6F00);
    $display("test system calibration done");
  endtask
  task automatic t_pd();
    bus(1'b1, ACPS_ADDR_CTRL, 32'h34);
    repeat (2100) @(negedge clock_i);
    chk(32'(rdy_n), 32'h1);
    c = clk_pin;
    t0 = cycles;
    while (clk_pin === c && cycles - t0 < 20) begin
      @(negedge clock_i);
    end
    chk(32'(clk_pin !== c), 32'h1);
    bus(1'b1, ACPS_ADDR_CTRL, 32'hB4);
    repeat (4) @(negedge clock_i);
    chk(32'(osc_en), 32'h0);
    rd(ACPS_ADDR_OFFSET1, 32'h100);
    rd(ACPS_ADDR_GAIN0, 32'(FC - ZC));
    bus(1'b1, ACPS_ADDR_CTRL, 32'h30);
    t0 = cycles;
    wait_odr(3);
    bus(1'b1, ACPS_ADDR_CTRL, 32'h34);
    repeat (2100) @(negedge clock_i);
    chk(32'(rdy_n), 32'h0);
    rd(ACPS_ADDR_DATA, 32'h6F00);
    chk(32'(rdy_n), 32'h1);
    bus(1'b1, ACPS_ADDR_CTRL, 32'h3B);
    repeat (3300) @(negedge clock_i);
    chk(32'(mod_rst), 32'h1);
    chk(32'(rdy_n), 32'h1);
    rd(ACPS_ADDR_CTRL, 32'h3B);
    $display("test power-down done");
  endtask
  initial begin
    rst_n_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    level = 16'h5555;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_self();
    t_sys();
    t_pd();
    end_of_test();
  end
endmodule // tb
